// File: hdl/if_resonator_tuning_control.sv
// resonator tuning control with serial control port and register file
`timescale 1ns/10ps
module if_resonator_tuning_control #(
    parameter int unsigned TUNE_LIMIT = if_tuning_pkg::TUNE_LIMIT_CYCLES,
    parameter logic [15:0] SETTLE = if_tuning_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial control port
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // analog tuning comparator, high when capacitance is too large
    input wire logic tune_compare,
    // analog and datapath controls
    output logic [7:0] block_standby_control,
    output logic input_attenuator_enable,
    output logic [if_tuning_pkg::TANK_CODE_W-1:0] tank_cap_code,
    output logic [if_tuning_pkg::RC_CODE_W-1:0] rc_cap_code,
    output logic sample_port_en
);
    import if_tuning_pkg::*;

    // ==========================================
    // input synchronisation
    logic s_sclk, s_cs_n, s_sdi, s_cmp;
    logic sclk_prev_q;
    logic sclk_rise, sclk_fall;

    sync_stage #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({spi_sclk, spi_cs_n, spi_sdi, tune_compare}),
        .sync_out({s_sclk, s_cs_n, s_sdi, s_cmp})
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= s_sclk;
        end
    end

    assign sclk_rise = s_sclk & ~sclk_prev_q & ~s_cs_n;
    assign sclk_fall = ~s_sclk & sclk_prev_q & ~s_cs_n;

    // ==========================================
    // serial frame: r/w, 7-bit address, 8-bit data, msb first
    logic [FRAME_BITS-1:0] shift_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] tx_q;
    logic rd_phase_q;
    logic rd_load, wr_stb;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [7:0] wr_data, rd_value;

    assign rd_load = sclk_rise && bit_cnt_q == CNT_RW_LAST && shift_q[6];
    assign rd_addr = {shift_q[5:0], s_sdi};
    assign wr_stb = sclk_rise && bit_cnt_q == CNT_FRAME_LAST && !shift_q[14];
    assign wr_addr = shift_q[13:7];
    assign wr_data = {shift_q[6:0], s_sdi};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
        end else if (s_cs_n) begin
            bit_cnt_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], s_sdi};
            if (bit_cnt_q != CNT_SAT) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // read data launched on falling edges, host samples on rising
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_q <= '0;
            rd_phase_q <= 1'b0;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (s_cs_n) begin
            rd_phase_q <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            if (rd_load) begin
                tx_q <= rd_value;
                rd_phase_q <= 1'b1;
            end else if (sclk_fall && rd_phase_q) begin
                spi_sdo <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                spi_sdo_oe <= 1'b1;
            end
        end
    end

    // ==========================================
    // tuning state
    tune_state_t state_q;
    logic [3:0] bit_idx_q;
    logic [15:0] settle_q;
    logic [31:0] tune_cnt_q;
    logic lc_req_q, rc_req_q;
    logic adc_release, start, step, timeout, phase_end;
    logic idle;

    assign idle = state_q == ST_IDLE;
    assign adc_release = wr_stb && wr_addr == ADDR_STANDBY &&
        block_standby_control[ADC_BLOCK_STANDBY_CONTROL_BIT] && !wr_data[ADC_BLOCK_STANDBY_CONTROL_BIT];
    assign start = idle && adc_release && (lc_req_q || rc_req_q);
    assign step = settle_q == SETTLE - 16'h0001;
    assign timeout = tune_cnt_q == TUNE_LIMIT - 1;
    assign phase_end = !idle && ((step && bit_idx_q == 4'h0) || timeout);

    // ==========================================
    // read mux
    always_comb begin
        rd_value = 8'h00;
        unique case (rd_addr)
            ADDR_STANDBY: rd_value = block_standby_control;
            ADDR_INPUT_ATTENUATOR_ENABLE_CTRL: rd_value = {input_attenuator_enable, 7'h00};
            ADDR_TUNE_REQ: rd_value = {6'h00, lc_req_q, rc_req_q};
            // tank code split over two registers
            ADDR_TANK_UPPER: rd_value = {5'h00, tank_cap_code[8:6]};
            ADDR_TANK_LOWER: rd_value = {2'h0, tank_cap_code[5:0]};
            ADDR_RC_CODE: rd_value = rc_cap_code;
            default: rd_value = 8'h00;
        endcase
    end

    // ==========================================
    // control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            block_standby_control <= STANDBY_RESET;
            input_attenuator_enable <= 1'b0;
        end else if (wr_stb) begin
            if (wr_addr == ADDR_STANDBY) begin
                block_standby_control <= wr_data;
            end
            // attenuator enable drives the mixer gain step
            if (wr_addr == ADDR_INPUT_ATTENUATOR_ENABLE_CTRL) begin
                input_attenuator_enable <= wr_data[INPUT_ATTENUATOR_ENABLE_BIT];
            end
        end
    end

    // host write wins over the self-clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lc_req_q <= 1'b0;
            rc_req_q <= 1'b0;
        end else if (wr_stb && wr_addr == ADDR_TUNE_REQ) begin
            lc_req_q <= wr_data[TANK_REQ_BIT];
            rc_req_q <= wr_data[RC_REQ_BIT];
        end else begin
            // request self-clears at end of phase
            if (state_q == ST_TANK && phase_end) begin
                lc_req_q <= 1'b0;
            end
            // timeout ends the whole run, so both requests drop
            if ((state_q == ST_RC || timeout) && phase_end) begin
                rc_req_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_idx_q <= '0;
            settle_q <= '0;
            tune_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    settle_q <= '0;
                    tune_cnt_q <= '0;
                    if (start) begin
                        state_q <= lc_req_q ? ST_TANK : ST_RC;
                        bit_idx_q <= lc_req_q ? TANK_TOP_IDX : RC_TOP_IDX;
                    end
                end
                ST_TANK, ST_RC: begin
                    tune_cnt_q <= tune_cnt_q + 32'h1;
                    settle_q <= step ? 16'h0000 : settle_q + 16'h0001;
                    if (phase_end) begin
                        settle_q <= '0;
                        bit_idx_q <= RC_TOP_IDX;
                        // rc follows tank when both requested
                        if (state_q == ST_TANK && rc_req_q && !timeout) begin
                            state_q <= ST_RC;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else if (step) begin
                        bit_idx_q <= bit_idx_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // capacitor codes, successive approximation
    // codes have no standby reset, so they survive power-save cycles
    // codes kept over standby
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tank_cap_code <= TANK_CODE_RESET;
            rc_cap_code <= RC_CODE_RESET;
        end else if (idle) begin
            // search starts from the midscale trial
            if (start && lc_req_q) begin
                tank_cap_code <= TANK_FIRST_TRIAL;
            end else if (start) begin
                rc_cap_code <= RC_FIRST_TRIAL;
            end else if (wr_stb && wr_addr == ADDR_TANK_UPPER) begin
                tank_cap_code[8:6] <= wr_data[2:0];
            end else if (wr_stb && wr_addr == ADDR_TANK_LOWER) begin
                tank_cap_code[5:0] <= wr_data[TANK_LOWER_W-1:0];
            end else if (wr_stb && wr_addr == ADDR_RC_CODE) begin
                rc_cap_code <= wr_data;
            end
        end else if (state_q == ST_TANK) begin
            // decide one bit per settled step
            if (step) begin
                if (s_cmp) begin
                    tank_cap_code[bit_idx_q] <= 1'b0;
                end
                if (bit_idx_q != 4'h0) begin
                    tank_cap_code[bit_idx_q - 4'h1] <= 1'b1;
                end
            end
            if (phase_end && rc_req_q && !timeout) begin
                rc_cap_code <= RC_FIRST_TRIAL;
            end
        end else if (step) begin
            if (s_cmp) begin
                rc_cap_code[bit_idx_q[2:0]] <= 1'b0;
            end
            if (bit_idx_q != 4'h0) begin
                rc_cap_code[3'(bit_idx_q - 4'h1)] <= 1'b1;
            end
        end
    end

    // ==========================================
    // sample port gate
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_port_en <= 1'b0;
        end else begin
            sample_port_en <= idle && !start &&
                !block_standby_control[ADC_BLOCK_STANDBY_CONTROL_BIT];
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_input_attenuator_enable_write;
        wr_stb && wr_addr == ADDR_INPUT_ATTENUATOR_ENABLE_CTRL |=>
            input_attenuator_enable == $past(wr_data[INPUT_ATTENUATOR_ENABLE_BIT]);
    endproperty
    a_input_attenuator_enable_write: assert property (p_input_attenuator_enable_write)
        else $error("attenuator bit not taken from write");

    property p_tank_start;
        idle && adc_release && lc_req_q |=> state_q == ST_TANK;
    endproperty
    a_tank_start: assert property (p_tank_start)
        else $error("tank tuning did not start on adc release");

    property p_tune_bound;
        tune_cnt_q < TUNE_LIMIT;
    endproperty
    a_tune_bound: assert property (p_tune_bound)
        else $error("tuning exceeded time limit");

    property p_req_clear;
        state_q == ST_TANK && phase_end &&
            !(wr_stb && wr_addr == ADDR_TUNE_REQ) |=> !lc_req_q;
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("tank request not cleared at end");

    property p_upper_read;
        rd_load && rd_addr == ADDR_TANK_UPPER |=>
            tx_q == {5'h00, $past(tank_cap_code[8:6])};
    endproperty
    a_upper_read: assert property (p_upper_read)
        else $error("upper tank code read wrong");

    property p_standby_keeps;
        idle && !start && wr_stb && wr_addr == ADDR_STANDBY |=>
            $stable(tank_cap_code) && $stable(rc_cap_code);
    endproperty
    a_standby_keeps: assert property (p_standby_keeps)
        else $error("standby write disturbed codes");

    property p_manual_lower;
        idle && !start && wr_stb && wr_addr == ADDR_TANK_LOWER |=>
            tank_cap_code[5:0] == $past(wr_data[5:0]);
    endproperty
    a_manual_lower: assert property (p_manual_lower)
        else $error("manual tank code write lost");

    property p_rc_follows;
        state_q == ST_TANK && phase_end && rc_req_q && !timeout |=>
            state_q == ST_RC;
    endproperty
    a_rc_follows: assert property (p_rc_follows)
        else $error("rc phase did not follow tank");

    property p_port_quiet;
        !idle |=> !sample_port_en;
    endproperty
    a_port_quiet: assert property (p_port_quiet)
        else $error("sample port active during tuning");

    property p_first_trial;
        start && lc_req_q |=> tank_cap_code == TANK_FIRST_TRIAL ##1
            (state_q == ST_TANK && bit_idx_q == TANK_TOP_IDX);
    endproperty
    a_first_trial: assert property (p_first_trial)
        else $error("tank search did not begin at midscale");

    c_tank_done: cover property (state_q == ST_TANK && phase_end);
    c_both_done: cover property (state_q == ST_RC && phase_end && !lc_req_q);
    c_read: cover property (rd_load && rd_addr == ADDR_TANK_LOWER);
    c_timeout: cover property (timeout && !idle);

endmodule

// File: hdl/if_tuning_pkg.sv
// constants and types for the resonator tuning control block
package if_tuning_pkg;

    // ==========================================
    // serial control frame
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 7;
    localparam logic [4:0] CNT_RW_LAST = 5'h07;
    localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;
    localparam logic [4:0] CNT_SAT = 5'h1F;

    // ==========================================
    // register offsets
    localparam logic [6:0] ADDR_STANDBY = 7'h00;
    localparam logic [6:0] ADDR_INPUT_ATTENUATOR_ENABLE_CTRL = 7'h03;
    localparam logic [6:0] ADDR_TUNE_REQ = 7'h1C;
    localparam logic [6:0] ADDR_TANK_UPPER = 7'h1D;
    localparam logic [6:0] ADDR_TANK_LOWER = 7'h1E;
    localparam logic [6:0] ADDR_RC_CODE = 7'h1F;

    // ==========================================
    // field positions and reset values
    localparam int INPUT_ATTENUATOR_ENABLE_BIT = 7;
    localparam int ADC_BLOCK_STANDBY_CONTROL_BIT = 0;
    localparam int TANK_REQ_BIT = 1;
    localparam int RC_REQ_BIT = 0;
    localparam logic [7:0] STANDBY_RESET = 8'hFF;
    localparam int TANK_CODE_W = 9;
    localparam int TANK_LOWER_W = 6;
    localparam int RC_CODE_W = 8;
    localparam logic [8:0] TANK_CODE_RESET = 9'h000;
    localparam logic [7:0] RC_CODE_RESET = 8'h00;
    localparam logic [8:0] TANK_FIRST_TRIAL = 9'h100;
    localparam logic [7:0] RC_FIRST_TRIAL = 8'h80;
    localparam logic [3:0] TANK_TOP_IDX = 4'h8;
    localparam logic [3:0] RC_TOP_IDX = 4'h7;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TUNE_LIMIT_NS = 6000000;
    // longest time, rounded down
    localparam int TUNE_LIMIT_CYCLES = TUNE_LIMIT_NS / CLK_PERIOD_NS;
    localparam logic [15:0] SETTLE_CYCLES = 16'h03E8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TANK,
        ST_RC
    } tune_state_t;

endpackage

// File: hdl/sync_stage.sv
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // async in, synced out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: sim/host_spi_model.sv
// host model driving the serial control port as frame master
`timescale 1ns/10ps
module host_spi_model (
    // clock
    input wire logic core_clk,
    // serial control port
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe
);
    import if_tuning_pkg::*;
    // released line reads inverted, so a missing enable corrupts data
    logic sdo_line;
    assign sdo_line = spi_sdo_oe ? spi_sdo : ~spi_sdo;
    // ==========================================
    // frame timing
    // half period of 4 core clocks gives the 200 ns link clock
    localparam int HALF = 4;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ==========================================
    // one 16 bit frame, msb first
    task automatic xfer(input logic rd, input logic [6:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        wait_clk(1);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = frame[i];
            wait_clk(HALF);
            spi_sclk = 1'b1;
            // read data taken on the rising edge
            if (i < 8) begin
                rdata[i] = sdo_line;
            end
            wait_clk(HALF);
            spi_sclk = 1'b0;
        end
        wait_clk(HALF);
        spi_cs_n = 1'b1;
        // released line must not look like held data
        spi_sdi = ~spi_sdi;
        wait_clk(6);
    endtask

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        xfer(1'b0, addr, data, unused);
    endtask

    // ==========================================
    // startup tune sequence
    // clock runs from time zero, no lo or if drive exists in this bench
    task automatic tune_seq;
        wr(ADDR_STANDBY, 8'h45);
        wr(ADDR_TUNE_REQ, 8'h03);
        wr(ADDR_STANDBY, 8'h44);
    endtask
endmodule

// File: sim/tb_if_resonator_tuning_control.sv
// self-checking bench for the resonator tuning control block
`timescale 1ns/10ps
module tb_if_resonator_tuning_control;
    import if_tuning_pkg::*;
    // ==========================================
    // shortened counts keep the run short
    localparam int unsigned LIMIT = 1000;
    localparam logic [15:0] SETTLE_SIM = 16'h0028;
    logic core_clk, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
    logic tune_compare, input_attenuator_enable, sample_port_en;
    logic [7:0] block_standby_control, rc_cap_code;
    logic [8:0] tank_cap_code, tank_target;
    logic [7:0] rc_target;
    int fails = 0;
    int compares = 0;

    // comparator stand-in: high when trial code exceeds the target
    assign tune_compare = (tank_cap_code > tank_target) |
                          (rc_cap_code > rc_target);

    if_resonator_tuning_control #(.TUNE_LIMIT(LIMIT), .SETTLE(SETTLE_SIM))
    u_dut (
        .core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .tune_compare(tune_compare),
        .block_standby_control(block_standby_control),
        .input_attenuator_enable(input_attenuator_enable),
        .tank_cap_code(tank_cap_code), .rc_cap_code(rc_cap_code),
        .sample_port_en(sample_port_en)
    );

    host_spi_model u_host (
        .core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe)
    );

    // ==========================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.xfer(1'b1, addr, 8'h00, d);
        check($sformatf("reg %h", addr), 16'(d), 16'(exp));
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        check("standby out", 16'(block_standby_control), 16'h00FF);
        check("port enable", 16'(sample_port_en), 16'h0000);
        rdchk(ADDR_STANDBY, 8'hFF);
        rdchk(ADDR_INPUT_ATTENUATOR_ENABLE_CTRL, 8'h00);
        rdchk(ADDR_TUNE_REQ, 8'h00);
        rdchk(ADDR_TANK_UPPER, 8'h00);
        rdchk(ADDR_TANK_LOWER, 8'h00);
        rdchk(ADDR_RC_CODE, 8'h00);
        // unmapped place reads zero
        rdchk(7'h05, 8'h00);
    endtask

    task automatic t_input_attenuator_enable;
        u_host.wr(ADDR_INPUT_ATTENUATOR_ENABLE_CTRL, 8'h80);
        check("input_attenuator_enable on", 16'(input_attenuator_enable), 16'h0001);
        rdchk(ADDR_INPUT_ATTENUATOR_ENABLE_CTRL, 8'h80);
        // only the top bit counts
        u_host.wr(ADDR_INPUT_ATTENUATOR_ENABLE_CTRL, 8'h7F);
        check("input_attenuator_enable off", 16'(input_attenuator_enable), 16'h0000);
    endtask

    task automatic t_manual;
        u_host.wr(ADDR_TANK_UPPER, 8'hFF);
        u_host.wr(ADDR_TANK_LOWER, 8'hFF);
        rdchk(ADDR_TANK_UPPER, 8'h07);
        rdchk(ADDR_TANK_LOWER, 8'h3F);
        check("tank all", 16'(tank_cap_code), 16'h01FF);
        u_host.wr(ADDR_TANK_UPPER, 8'h05);
        u_host.wr(ADDR_TANK_LOWER, 8'h2A);
        check("tank manual", 16'(tank_cap_code), 16'h016A);
    endtask

    task automatic t_tank_only;
        int n;
        tank_target = 9'h0B3;
        u_host.wr(ADDR_STANDBY, 8'h45);
        u_host.wr(ADDR_TUNE_REQ, 8'h02);
        u_host.wr(ADDR_STANDBY, 8'h44);
        check("busy port", 16'(sample_port_en), 16'h0000);
        n = 0;
        while (sample_port_en !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("tank time", 16'(n < LIMIT), 16'h0001);
        check("tank code", 16'(tank_cap_code), 16'(tank_target));
        check("rc idle", 16'(rc_cap_code), 16'h0000);
        rdchk(ADDR_TUNE_REQ, 8'h00);
        rdchk(ADDR_TANK_UPPER, 8'h02);
        rdchk(ADDR_TANK_LOWER, 8'h33);
    endtask

    task automatic t_both;
        logic [7:0] rc0;
        logic seen_rc;
        int n;
        tank_target = 9'h1C6;
        rc_target = 8'h5B;
        rc0 = rc_cap_code;
        seen_rc = 1'b0;
        u_host.tune_seq();
        // manual write while busy must be dropped
        u_host.wr(ADDR_TANK_LOWER, 8'h3F);
        rdchk(ADDR_TUNE_REQ, 8'h03);
        // frames so far spent about 300 cycles of the search
        n = 300;
        while (sample_port_en !== 1'b1 && n < 2000) begin
            if (!seen_rc && rc_cap_code !== rc0) begin
                seen_rc = 1'b1;
                check("tank first", 16'(tank_cap_code),
                      16'(tank_target));
            end
            @(posedge core_clk);
            #1;
            n++;
        end
        check("both time", 16'(n < LIMIT), 16'h0001);
        check("tank end", 16'(tank_cap_code), 16'(tank_target));
        check("rc final", 16'(rc_cap_code), 16'(rc_target));
        rdchk(ADDR_RC_CODE, 8'h5B);
        rdchk(ADDR_TUNE_REQ, 8'h00);
    endtask

    task automatic t_keep;
        u_host.wr(ADDR_STANDBY, 8'h45);
        check("standby port", 16'(sample_port_en), 16'h0000);
        u_host.wr(ADDR_STANDBY, 8'h44);
        repeat (4) @(posedge core_clk);
        #1;
        check("no retune", 16'(sample_port_en), 16'h0001);
        check("tank kept", 16'(tank_cap_code), 16'h01C6);
        check("rc kept", 16'(rc_cap_code), 16'h005B);
        rdchk(ADDR_TANK_LOWER, 8'h06);
    endtask

    // ==========================================
    // clock, reset, sequence and watchdog
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        rst = 1'b1;
        tank_target = 9'h1FF;
        rc_target = 8'hFF;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        t_reset();
        t_input_attenuator_enable();
        t_manual();
        t_tank_only();
        t_both();
        t_keep();
        tally_and_finish();
    end

    // 32 frames and three searches fit well inside this span
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
endmodule
